// ===== core/cmpif_top.sv
`timescale 1ns/1ns
module cmpif_top #(
    parameter int MEAS_CYCLES = cmpif_pkg::MEAS_CYCLES_DEF
) (
    // Clock and resets
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic EXTERNAL_RESET_N,
    // Four-wire and two-wire pins
    input wire logic FOUR_WIRE_SELECT_N,
    input wire logic FOUR_WIRE_CLOCK_IN,
    input wire logic SERIAL_DATA_IN,
    output logic SDA_OE,
    output logic SERIAL_DATA_OUT,
    output logic SERIAL_DATA_OUT_OE,
    // Address straps
    input wire logic ADDR_STRAP_0,
    input wire logic ADDR_STRAP_1,
    output logic TWO_WIRE_MODE,
    output logic [6:0] TWO_WIRE_ADDRESS,
    // Sequencer and sensor front end
    input wire logic SEQUENCER_OSCILLATOR,
    input wire cmpif_pkg::cmpif_sample_s SENSOR_DATA,
    output logic SENSOR_DRIVE_EN,
    output logic SELF_TEST_SOURCE_EN,
    // Results
    output logic RESULT_READY_OUT,
    output cmpif_pkg::cmpif_sample_s RESULT_DATA,
    input wire logic RESULT_POP,
    output logic [cmpif_pkg::PTR_W:0] FIFO_LEVEL,
    output logic OVERFLOW_FLAG,
    output logic [1:0] MODE_OUT,
    output logic NOISE_FILTER_OUT
);

    // ------------------------------------------------------------
    // State types
    // ------------------------------------------------------------
    typedef struct packed
    {
        cmpif_pkg::cmpif_state_e state;
        logic [1:0] mode;
        logic noise_filter;
        logic [cmpif_pkg::CNT_W-1:0] cnt;
        cmpif_pkg::cmpif_sample_s prev;
        logic prev_valid;
        logic [cmpif_pkg::PTR_W:0] wr_ptr;
        logic [cmpif_pkg::PTR_W:0] rd_ptr;
        logic ovf;
        logic [2:0] tog_sync;
        logic [2:0] seq_sync;
        logic [1:0] xrst_sync;
        logic [1:0] cs_sync;
        logic [1:0] strap0_sync;
        logic [1:0] strap1_sync;
    } cmpif_core_s;

    typedef struct packed
    {
        logic [2:0] bit_cnt;
        logic [cmpif_pkg::CMD_W-1:0] shift;
    } cmpif_link_s;

    localparam logic [cmpif_pkg::CNT_W-1:0] MEAS_LOAD = cmpif_pkg::CNT_W'(MEAS_CYCLES - 1);

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic logic [cmpif_pkg::AXIS_W-1:0] avg16(
        input logic [cmpif_pkg::AXIS_W-1:0] a,
        input logic [cmpif_pkg::AXIS_W-1:0] b
    );
        logic [cmpif_pkg::AXIS_W:0] sum;
        sum = {a[cmpif_pkg::AXIS_W-1], a} + {b[cmpif_pkg::AXIS_W-1], b};
        return sum[cmpif_pkg::AXIS_W:1];
    endfunction

    function automatic logic starts_once(input logic [1:0] m);
        return (m == cmpif_pkg::MODE_SINGLE) || (m == cmpif_pkg::MODE_SELF_TEST);
    endfunction

    // ------------------------------------------------------------
    // Link domain: four-wire receive, mode 3
    // ------------------------------------------------------------
    cmpif_link_s link_q;
    cmpif_link_s link_d;
    logic link_rst_n;
    logic [cmpif_pkg::CMD_W-1:0] cmd_hold_q;
    logic cmd_tog_q;
    logic [cmpif_pkg::CMD_W-1:0] rx_byte;

    // Chip select high holds the shifter in reset, ending each frame
    assign link_rst_n = RESET_N & ~FOUR_WIRE_SELECT_N;
    assign rx_byte = {link_q.shift[cmpif_pkg::CMD_W-2:0], SERIAL_DATA_IN};

    always_comb
    begin
        link_d = link_q;
        link_d.shift = rx_byte;
        link_d.bit_cnt = link_q.bit_cnt + 3'h1;
    end

    always_ff @(posedge FOUR_WIRE_CLOCK_IN or negedge link_rst_n)
    begin
        if (!link_rst_n)
        begin
            link_q <= '0;
        end
        else
        begin
            link_q <= link_d;
        end
    end

    // Held word and toggle survive chip select; core reads hold after toggle settles
    always_ff @(posedge FOUR_WIRE_CLOCK_IN or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            cmd_hold_q <= cmpif_pkg::CFG_RESET;
            cmd_tog_q <= 1'b0;
        end
        else if (!FOUR_WIRE_SELECT_N && link_q.bit_cnt == 3'h7)
        begin
            cmd_hold_q <= rx_byte;
            cmd_tog_q <= ~cmd_tog_q;
        end
    end

    // Echo of previously shifted bits; no edges exist outside a frame
    assign SERIAL_DATA_OUT = link_q.shift[cmpif_pkg::CMD_W-1];
    assign SERIAL_DATA_OUT_OE = ~FOUR_WIRE_SELECT_N;
    assign SDA_OE = 1'b0;

    // ------------------------------------------------------------
    // Core domain on the measurement clock
    // ------------------------------------------------------------
    cmpif_core_s core_q;
    cmpif_core_s core_d;
    cmpif_pkg::cmpif_sample_s fifo_mem [cmpif_pkg::FIFO_DEPTH];
    cmpif_pkg::cmpif_sample_s filt;
    logic push;
    logic pop;
    logic full;
    logic empty;
    logic cmd_evt;
    logic seq_tick;

    assign empty = core_q.wr_ptr == core_q.rd_ptr;
    assign full = (core_q.wr_ptr[cmpif_pkg::PTR_W] != core_q.rd_ptr[cmpif_pkg::PTR_W])
        && (core_q.wr_ptr[cmpif_pkg::PTR_W-1:0] == core_q.rd_ptr[cmpif_pkg::PTR_W-1:0]);
    assign cmd_evt = core_q.tog_sync[2] ^ core_q.tog_sync[1];
    assign seq_tick = core_q.seq_sync[1] & ~core_q.seq_sync[2];
    assign pop = RESULT_POP & ~empty;
    assign push = (core_q.state == cmpif_pkg::ST_STORE) & ~full;

    // Filter averages with the previous set; first set passes unchanged
    always_comb
    begin
        filt = SENSOR_DATA;
        if (core_q.noise_filter && core_q.prev_valid)
        begin
            filt.x = avg16(SENSOR_DATA.x, core_q.prev.x);
            filt.y = avg16(SENSOR_DATA.y, core_q.prev.y);
            filt.z = avg16(SENSOR_DATA.z, core_q.prev.z);
        end
    end

    always_comb
    begin
        core_d = core_q;
        core_d.tog_sync = {core_q.tog_sync[1:0], cmd_tog_q};
        core_d.seq_sync = {core_q.seq_sync[1:0], SEQUENCER_OSCILLATOR};
        core_d.xrst_sync = {core_q.xrst_sync[0], EXTERNAL_RESET_N};
        core_d.cs_sync = {core_q.cs_sync[0], FOUR_WIRE_SELECT_N};
        core_d.strap0_sync = {core_q.strap0_sync[0], ADDR_STRAP_0};
        core_d.strap1_sync = {core_q.strap1_sync[0], ADDR_STRAP_1};
        if (cmd_evt)
        begin
            core_d.mode = cmd_hold_q[cmpif_pkg::CFG_MODE_LSB +: 2];
            core_d.noise_filter = cmd_hold_q[cmpif_pkg::CFG_FILTER_BIT];
        end
        if (pop)
        begin
            core_d.rd_ptr = core_q.rd_ptr + 1'b1;
        end
        case (core_q.state)
            cmpif_pkg::ST_IDLE:
            begin
                if (starts_once(core_d.mode)
                    || (core_d.mode == cmpif_pkg::MODE_CONTINUOUS && seq_tick))
                begin
                    core_d.state = cmpif_pkg::ST_CONVERT;
                    core_d.cnt = MEAS_LOAD;
                end
            end
            cmpif_pkg::ST_CONVERT:
            begin
                core_d.cnt = core_q.cnt - 1'b1;
                if (core_q.cnt == '0)
                begin
                    core_d.state = cmpif_pkg::ST_STORE;
                end
            end
            cmpif_pkg::ST_STORE:
            begin
                // A full store drops the new set rather than corrupting older ones
                if (push)
                begin
                    core_d.wr_ptr = core_q.wr_ptr + 1'b1;
                end
                core_d.prev = SENSOR_DATA;
                core_d.prev_valid = 1'b1;
                core_d.ovf = SENSOR_DATA.overflow;
                if (starts_once(core_q.mode) && !cmd_evt)
                begin
                    core_d.mode = cmpif_pkg::MODE_POWER_DOWN;
                end
                core_d.state = cmpif_pkg::ST_IDLE;
            end
            default:
            begin
                core_d.state = cmpif_pkg::ST_IDLE;
            end
        endcase
        // Pin reset clears everything but its own synchroniser and the command toggle synchroniser
        if (!core_q.xrst_sync[1])
        begin
            core_d = '0;
            core_d.xrst_sync = {core_q.xrst_sync[0], EXTERNAL_RESET_N};
            core_d.tog_sync = {core_q.tog_sync[1:0], cmd_tog_q};
        end
    end

    // Power-on reset lands in power-down with an empty store
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            core_q <= '0;
        end
        else
        begin
            core_q <= core_d;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (push)
        begin
            fifo_mem[core_q.wr_ptr[cmpif_pkg::PTR_W-1:0]] <= filt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign RESULT_READY_OUT = ~empty;
    assign RESULT_DATA = empty ? '0 : fifo_mem[core_q.rd_ptr[cmpif_pkg::PTR_W-1:0]];
    assign FIFO_LEVEL = core_q.wr_ptr - core_q.rd_ptr;
    assign OVERFLOW_FLAG = core_q.ovf;
    assign MODE_OUT = core_q.mode;
    assign NOISE_FILTER_OUT = core_q.noise_filter;
    assign SENSOR_DRIVE_EN = core_q.state == cmpif_pkg::ST_CONVERT;
    assign SELF_TEST_SOURCE_EN = (core_q.state == cmpif_pkg::ST_CONVERT)
        && (core_q.mode == cmpif_pkg::MODE_SELF_TEST);
    assign TWO_WIRE_MODE = core_q.cs_sync[1];
    assign TWO_WIRE_ADDRESS = {cmpif_pkg::TWO_WIRE_ADDR_BASE,
        core_q.strap1_sync[1], core_q.strap0_sync[1]};

endmodule

// ===== core/cmpif_pkg.sv
package cmpif_pkg;

    // ------------------------------------------------------------
    // Widths and depths
    // ------------------------------------------------------------
    localparam int AXIS_W = 16;
    localparam int FIFO_DEPTH = 32;
    localparam int PTR_W = 5;
    localparam int CMD_W = 8;
    localparam int CNT_W = 18;

    // ------------------------------------------------------------
    // Configuration byte layout and reset value
    // ------------------------------------------------------------
    localparam int CFG_MODE_LSB = 0;
    localparam int CFG_FILTER_BIT = 2;
    localparam logic [1:0] MODE_POWER_DOWN = 2'h0;
    localparam logic [1:0] MODE_SINGLE = 2'h1;
    localparam logic [1:0] MODE_CONTINUOUS = 2'h2;
    localparam logic [1:0] MODE_SELF_TEST = 2'h3;
    localparam logic [7:0] CFG_RESET = 8'h00;

    // Upper address bits are arbitrary
    localparam logic [4:0] TWO_WIRE_ADDR_BASE = 5'h03;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam longint CLK_HZ = 20000000;
    localparam longint MEAS_TIME_US = 8500;
    localparam int MEAS_CYCLES_DEF = int'((MEAS_TIME_US * CLK_HZ) / 1000000);
    localparam longint TWO_WIRE_HS_MAX_HZ = 2500000;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_CONVERT = 2'b01,
        ST_STORE = 2'b11
    } cmpif_state_e;

    typedef struct packed
    {
        logic [AXIS_W-1:0] x;
        logic [AXIS_W-1:0] y;
        logic [AXIS_W-1:0] z;
        logic overflow;
    } cmpif_sample_s;

endpackage

// ===== tb/cmpif_host_model.sv
`timescale 1ns/1ns
module cmpif_host_model (
    // Link pins driven by the host
    output logic sel_n,
    output logic sck,
    output logic sdi
);
    initial
    begin
        sel_n = 1'b1;
        sck = 1'b1;
        sdi = 1'b0;
    end

    // -----------------------------
    // Frame, MSB first; n below 8 gives a partial byte
    // -----------------------------
    task automatic frame(input logic [7:0] b, input int n);
        #7 sel_n = 1'b0;
        for (int i = 7; i > 7 - n; i--)
        begin
            #80 sck = 1'b0;
            sdi = b[i];
            #80 sck = 1'b1;
        end
        #80 sel_n = 1'b1;
        // Released line must not keep showing the last bit
        sdi = ~sdi;
    endtask
endmodule

// ===== tb/cmpif_top_asserts.sv
`timescale 1ns/1ns
module cmpif_top_chk #(
    parameter int MEAS_CYCLES = 8
) (
    // Clock and resets
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic EXTERNAL_RESET_N,
    // Pins
    input wire logic FOUR_WIRE_SELECT_N,
    input wire logic SERIAL_DATA_OUT_OE,
    input wire logic ADDR_STRAP_0,
    input wire logic ADDR_STRAP_1,
    input wire logic [6:0] TWO_WIRE_ADDRESS,
    // Measurement and results
    input wire logic SENSOR_DRIVE_EN,
    input wire logic SELF_TEST_SOURCE_EN,
    input wire logic [1:0] MODE_OUT,
    input wire logic RESULT_READY_OUT,
    input wire cmpif_pkg::cmpif_sample_s RESULT_DATA,
    input wire logic RESULT_POP,
    input wire logic [cmpif_pkg::PTR_W:0] FIFO_LEVEL
);
    typedef struct packed
    {
        logic [31:0] cnt;
        logic seen;
    } cmpif_chk_s;
    cmpif_chk_s st_q, st_d;

    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    // -----------------------------
    // Drive length counter
    // -----------------------------
    always_comb
    begin
        st_d = st_q;
        st_d.cnt = SENSOR_DRIVE_EN ? st_q.cnt + 32'h1 : 32'h0;
        if (!SENSOR_DRIVE_EN && st_q.cnt != 32'h0)
            st_d.seen = 1'b1;
    end

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    a_out_enable: assert property (SERIAL_DATA_OUT_OE == !FOUR_WIRE_SELECT_N)
        else $error("serial output enable disagrees with select");
    a_strap_addr: assert property (
        (EXTERNAL_RESET_N && $stable({ADDR_STRAP_1, ADDR_STRAP_0}))[*8]
        |-> TWO_WIRE_ADDRESS == {cmpif_pkg::TWO_WIRE_ADDR_BASE, ADDR_STRAP_1, ADDR_STRAP_0})
        else $error("address does not follow straps");
    // Pin reset may cut a conversion short; such a drop is no finished measurement
    a_drive_len: assert property ($fell(SENSOR_DRIVE_EN) && $past(EXTERNAL_RESET_N, 3)
        |-> st_q.cnt == MEAS_CYCLES)
        else $error("drive length wrong");
    a_ready_push: assert property ($fell(SENSOR_DRIVE_EN) && FIFO_LEVEL == 6'd0
        && $past(EXTERNAL_RESET_N, 3) && $past(EXTERNAL_RESET_N, 2)
        |-> ##[1:2] RESULT_READY_OUT)
        else $error("ready missing after measurement");
    a_ready_first: assert property (!st_q.seen |-> !RESULT_READY_OUT)
        else $error("ready before first measurement");
    a_self_src: assert property ($rose(SENSOR_DRIVE_EN)
        |-> SELF_TEST_SOURCE_EN == (MODE_OUT == cmpif_pkg::MODE_SELF_TEST))
        else $error("self-test source wrong");
    a_full_hold: assert property (FIFO_LEVEL == 6'd32 && !RESULT_POP
        && $past(EXTERNAL_RESET_N, 2) |=> FIFO_LEVEL == 6'd32)
        else $error("full store changed");
    a_empty_data: assert property (!RESULT_READY_OUT |-> RESULT_DATA == '0)
        else $error("data shown while empty");
    // A single or self-test mode write in idle starts a conversion on the same edge that updates the mode
    a_pd_idle: assert property ($rose(SENSOR_DRIVE_EN)
        |-> MODE_OUT != cmpif_pkg::MODE_POWER_DOWN)
        else $error("drive in power-down");
endmodule

bind cmpif_top cmpif_top_chk #(.MEAS_CYCLES(MEAS_CYCLES)) cmpif_top_chk_i (
    .CLK, .RESET_N, .EXTERNAL_RESET_N, .FOUR_WIRE_SELECT_N, .SERIAL_DATA_OUT_OE,
    .ADDR_STRAP_0, .ADDR_STRAP_1, .TWO_WIRE_ADDRESS, .SENSOR_DRIVE_EN, .SELF_TEST_SOURCE_EN,
    .MODE_OUT, .RESULT_READY_OUT, .RESULT_DATA, .RESULT_POP, .FIFO_LEVEL
);

// ===== tb/tb.sv
`timescale 1ns/1ns
module tb;
    logic CLK, RESET_N, EXTERNAL_RESET_N, ADDR_STRAP_0, ADDR_STRAP_1, SEQUENCER_OSCILLATOR;
    logic RESULT_POP, sel_n, sck, sdi, TWO_WIRE_MODE, SERIAL_DATA_OUT_OE, RESULT_READY_OUT;
    logic OVERFLOW_FLAG, NOISE_FILTER_OUT, SDA_OE, SERIAL_DATA_OUT;
    logic [6:0] TWO_WIRE_ADDRESS;
    logic [1:0] MODE_OUT;
    logic [cmpif_pkg::PTR_W:0] FIFO_LEVEL;
    logic [15:0] seed;
    cmpif_pkg::cmpif_sample_s SENSOR_DATA, RESULT_DATA, exp_q[$];
    cmpif_pkg::cmpif_sample_s last;
    int error_cnt, comparisons;

    // Short measurement keeps the fill test brief
    cmpif_top #(.MEAS_CYCLES(8)) cmpif_top_i (
        .CLK, .RESET_N, .EXTERNAL_RESET_N, .FOUR_WIRE_SELECT_N(sel_n), .FOUR_WIRE_CLOCK_IN(sck),
        .SERIAL_DATA_IN(sdi), .SDA_OE, .SERIAL_DATA_OUT, .SERIAL_DATA_OUT_OE, .ADDR_STRAP_0,
        .ADDR_STRAP_1, .TWO_WIRE_MODE, .TWO_WIRE_ADDRESS, .SEQUENCER_OSCILLATOR, .SENSOR_DATA,
        .SENSOR_DRIVE_EN(), .SELF_TEST_SOURCE_EN(), .RESULT_READY_OUT, .RESULT_DATA, .RESULT_POP,
        .FIFO_LEVEL, .OVERFLOW_FLAG, .MODE_OUT, .NOISE_FILTER_OUT
    );
    cmpif_host_model cmpif_host_model_i (.sel_n, .sck, .sdi);

    initial
    begin
        CLK = 1'b0;
        forever #25 CLK = ~CLK;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // Signed mean of two axis words, rounded toward minus infinity
    function automatic logic [15:0] mean(input logic [15:0] a, input logic [15:0] b);
        logic signed [16:0] s;
        s = $signed(a) + $signed(b);
        return 16'(s >>> 1);
    endfunction

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("comparisons=%0d errors=%0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge CLK);
    endtask

    task automatic new_sample(input logic keep, input logic avg);
        logic [63:0] v;
        cmpif_pkg::cmpif_sample_s n;
        repeat (4)
        begin
            seed = lfsr(seed);
            v = {v[47:0], seed};
        end
        n = v[48:0];
        // Filter on: expect the mean of this raw set and the raw set before
        if (avg)
        begin
            n.x = mean(n.x, last.x);
            n.y = mean(n.y, last.y);
            n.z = mean(n.z, last.z);
        end
        last = v[48:0];
        SENSOR_DATA <= v[48:0];
        if (keep)
            exp_q.push_back(n);
    endtask

    task automatic send(input logic [7:0] b, input int n);
        cmpif_host_model_i.frame(b, n);
        cyc(7);
    endtask

    // Bounded wait for data, then a one-cycle pop
    task automatic pop_one();
        int k;
        k = 0;
        while (RESULT_READY_OUT !== 1'b1 && k < 200)
        begin
            cyc(1);
            k++;
        end
        if (k == 200)
        begin
            error_cnt++;
            complete_run();
        end
        RESULT_POP <= 1'b1;
        cyc(1);
        RESULT_POP <= 1'b0;
        cyc(1);
    endtask

    // Result monitor: oldest note against each popped set
    always @(posedge CLK)
        if (RESULT_POP && RESULT_READY_OUT)
            check(RESULT_DATA, exp_q.size() > 0 ? exp_q.pop_front() : '1);

    initial
    begin
        seed = 16'h0054;
        {RESET_N, EXTERNAL_RESET_N, RESULT_POP, SEQUENCER_OSCILLATOR} = 4'h4;
        {ADDR_STRAP_1, ADDR_STRAP_0} = 2'h0;
        SENSOR_DATA = '0;
        cyc(16);
        RESET_N <= 1'b1;
        cyc(6);
        check({TWO_WIRE_MODE, SERIAL_DATA_OUT_OE, SDA_OE, SERIAL_DATA_OUT}, 4'h8);
        check({RESULT_READY_OUT, MODE_OUT}, 3'h0);
        // Host settle time of 100 us before the first mode write
        cyc(2000);
        send(8'h02, 8);
        check(MODE_OUT, cmpif_pkg::MODE_CONTINUOUS);
        // Two extra ticks land on a full store and must be dropped
        for (int k = 0; k < 34; k++)
        begin
            new_sample(k < 32, 1'b0);
            SEQUENCER_OSCILLATOR <= 1'b1;
            cyc(3);
            SEQUENCER_OSCILLATOR <= 1'b0;
            cyc(16);
            if (k < 32)
                check(OVERFLOW_FLAG, SENSOR_DATA.overflow);
        end
        check(FIFO_LEVEL, 6'd32);
        send(8'h00, 8);
        repeat (32) pop_one();
        check({RESULT_READY_OUT, FIFO_LEVEL}, 7'h0);
        $display("fill and drain test done");
        for (int m = 1; m < 6; m += 2)
        begin
            new_sample(1'b1, m == 5);
            send(m[7:0], 8);
            pop_one();
            check(MODE_OUT, cmpif_pkg::MODE_POWER_DOWN);
        end
        $display("single and self-test done");
        send(8'h00, 7);
        check({NOISE_FILTER_OUT, MODE_OUT}, 3'h4);
        send(8'h06, 8);
        check({NOISE_FILTER_OUT, MODE_OUT}, 3'h6);
        EXTERNAL_RESET_N <= 1'b0;
        cyc(4);
        EXTERNAL_RESET_N <= 1'b1;
        cyc(4);
        check({NOISE_FILTER_OUT, MODE_OUT}, 3'h0);
        for (int s = 0; s < 4; s++)
        begin
            {ADDR_STRAP_1, ADDR_STRAP_0} <= s[1:0];
            cyc(8);
            check(TWO_WIRE_ADDRESS, {cmpif_pkg::TWO_WIRE_ADDR_BASE, s[1:0]});
        end
        $display("reset and strap test done");
        check(exp_q.size(), 0);
        complete_run();
    end
endmodule
